// File: inc/fsr_pkg.sv
// constants and carrier types for the flash status-reporting host controller
package fsr_pkg;

  // clock and timing (ns figures, cycle counts derived at 25 ns per cycle)
  localparam int CLK_NS        = 25;
  localparam int ACC_NS        = 150;
  localparam int SETTLE_NS     = 100;
  localparam int RST_LOW_NS    = 100;   // reset_low_pulse_time, plain default
  localparam int RST_REC_NS    = 1000;  // reset_recovery_time, plain default
  localparam int ACC_CYC       = (ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_CYC    = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_LOW_CYC   = (RST_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_REC_CYC   = (RST_REC_NS + CLK_NS - 1) / CLK_NS;
  localparam int TIM_W         = 16;
  localparam int BUF_TRIES     = 8;

  // device commands, plain defaults
  localparam logic [7:0] CMD_READ_ARRAY  = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ_ID     = 8'h90;
  localparam logic [7:0] CMD_BUF_WRITE   = 8'he8;
  localparam logic [7:0] CMD_CONFIRM     = 8'hd0;

  // status fields
  localparam int         MAIN_PROTECT_BIT = 1;
  localparam int         EXT_BUF_BIT      = 7;
  localparam logic [7:0] MAIN_MASK        = 8'hfa;
  localparam logic [7:0] EXT_MASK         = 8'h80;

  // identifier-space offsets and block layout
  localparam int          ADDR_W         = 23;
  localparam int          BLOCK_BITS     = 17;
  localparam logic [22:0] ID_BLOCK_OFS   = 23'h000002;
  localparam logic [22:0] ID_MASTER_OFS  = 23'h000003;

  typedef enum logic {
    FSR_OP_TWO_CYCLE,
    FSR_OP_BUFFER
  } fsr_op_t;

  typedef struct packed {
    fsr_op_t     kind;
    logic [7:0]  cmd;
    logic [22:0] addr;
    logic [15:0] data;
  } fsr_req_t;

  typedef struct packed {
    logic        wr;
    logic [22:0] addr;
    logic [15:0] data;
  } fsr_acc_t;

  typedef struct packed {
    logic [7:0]  main_status;
    logic [7:0]  ext_status;
    logic        protect;
    logic [7:0]  block_lock;
    logic [7:0]  master_lock;
  } fsr_result_t;

endpackage

// File: hdl/fsr_host.sv
// host controller that drives the flash pins and polls its status
`timescale 1ns/1ps
module fsr_host (
  // clock and reset
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_reset,
  // system control
  input  wire logic                 i_supply_ok,
  input  wire logic                 i_sys_reset,
  // user request and answer
  input  wire logic                 i_start,
  input  wire fsr_pkg::fsr_req_t    i_req,
  output logic                      o_busy,
  output logic                      o_done,
  output logic                      o_reissue_needed,
  output fsr_pkg::fsr_result_t      o_result,
  // flash pins
  output logic [22:0]               o_flash_addr,
  input  wire logic [15:0]          i_flash_dq,
  output logic [15:0]               o_flash_dq,
  output logic                      o_flash_dq_oe,
  output logic                      o_chip_select_a_n,
  output logic                      o_oe_n,
  output logic                      o_we_n,
  output logic                      o_reset_powerdown_n,
  input  wire logic                 i_completion_pin
);

  typedef enum logic [4:0] {
    ST_IDLE, ST_ACC, ST_GAP, ST_CMD2, ST_BUF_RD, ST_BUF_EVAL, ST_BUF_DAT, ST_BUF_CONF,
    ST_WAIT_LOW, ST_WAIT_DONE, ST_STAT_RD, ST_STAT_CHK, ST_ID_BLK, ST_ID_MST,
    ST_ID_END, ST_ARRAY, ST_FINISH, ST_RST_LOW, ST_RST_REC
  } fsr_state_t;

  fsr_state_t               state_q;
  fsr_state_t               ret_q;
  fsr_pkg::fsr_acc_t        acc_q;
  fsr_pkg::fsr_req_t        req_q;
  logic [fsr_pkg::TIM_W-1:0] tim_q;
  logic [3:0]               tries_q;
  logic [15:0]              rdata_q;
  logic                     rst_req;
  logic                     in_reset;
  logic [22:0]              blk_base;

  assign rst_req  = !i_supply_ok || i_sys_reset;
  assign in_reset = (state_q == ST_RST_LOW) || (state_q == ST_RST_REC);
  assign blk_base = {req_q.addr[22:fsr_pkg::BLOCK_BITS], {fsr_pkg::BLOCK_BITS{1'b0}}};

  // sequencer
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= ST_IDLE;
      ret_q   <= ST_IDLE;
      acc_q   <= '0;
      req_q   <= '0;
      tim_q   <= '0;
      tries_q <= '0;
    end else if (rst_req) begin
      // hold the pin low and restart the low-time count while asked
      state_q <= ST_RST_LOW;
      tim_q   <= fsr_pkg::TIM_W'(fsr_pkg::RST_LOW_CYC - 1);
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (i_start) begin
            req_q   <= i_req;
            tries_q <= 4'(fsr_pkg::BUF_TRIES - 1);
            acc_q   <= '{1'b1, i_req.addr,
                         {8'h00, (i_req.kind == fsr_pkg::FSR_OP_BUFFER) ?
                                 fsr_pkg::CMD_BUF_WRITE : i_req.cmd}};
            ret_q   <= (i_req.kind == fsr_pkg::FSR_OP_BUFFER) ? ST_BUF_RD : ST_CMD2;
            state_q <= ST_ACC;
            tim_q   <= fsr_pkg::TIM_W'(fsr_pkg::ACC_CYC - 1);
          end
        end
        ST_ACC: begin
          if (tim_q == '0) begin
            state_q <= ST_GAP;
          end else begin
            tim_q <= tim_q - 1'b1;
          end
        end
        ST_GAP: begin
          state_q <= ret_q;
          tim_q   <= fsr_pkg::TIM_W'(fsr_pkg::SETTLE_CYC - 1);
        end
        ST_WAIT_LOW: begin
          // the pin may lag the command; do not trust it at once
          if (tim_q == '0) begin
            state_q <= ST_WAIT_DONE;
          end else begin
            tim_q <= tim_q - 1'b1;
          end
        end
        ST_WAIT_DONE: begin
          // released pin reads high through the pull-up
          if (i_completion_pin) begin
            acc_q   <= '{1'b1, req_q.addr, {8'h00, fsr_pkg::CMD_READ_STATUS}};
            ret_q   <= ST_STAT_RD;
            state_q <= ST_ACC;
            tim_q   <= fsr_pkg::TIM_W'(fsr_pkg::ACC_CYC - 1);
          end
        end
        ST_BUF_EVAL: begin
          if (rdata_q[fsr_pkg::EXT_BUF_BIT]) begin
            acc_q   <= '{1'b1, req_q.addr, 16'h0000}; // one-word load count
            ret_q   <= ST_BUF_DAT;
          end else if (tries_q != '0) begin
            tries_q <= tries_q - 1'b1;
            acc_q   <= '{1'b1, req_q.addr, {8'h00, fsr_pkg::CMD_BUF_WRITE}};
            ret_q   <= ST_BUF_RD;
          end else begin
            acc_q   <= '{1'b1, req_q.addr, {8'h00, fsr_pkg::CMD_READ_ARRAY}};
            ret_q   <= ST_FINISH;
          end
          state_q <= ST_ACC;
          tim_q   <= fsr_pkg::TIM_W'(fsr_pkg::ACC_CYC - 1);
        end
        ST_STAT_CHK: begin
          if (rdata_q[fsr_pkg::MAIN_PROTECT_BIT]) begin
            acc_q <= '{1'b1, req_q.addr, {8'h00, fsr_pkg::CMD_READ_ID}};
            ret_q <= ST_ID_BLK;
          end else begin
            acc_q <= '{1'b1, req_q.addr, {8'h00, fsr_pkg::CMD_READ_ARRAY}};
            ret_q <= ST_FINISH;
          end
          state_q <= ST_ACC;
          tim_q   <= fsr_pkg::TIM_W'(fsr_pkg::ACC_CYC - 1);
        end
        ST_CMD2, ST_BUF_RD, ST_BUF_DAT, ST_BUF_CONF, ST_STAT_RD,
        ST_ID_BLK, ST_ID_MST, ST_ID_END, ST_ARRAY: begin
          unique case (state_q)
            ST_CMD2:     acc_q <= '{1'b1, req_q.addr, req_q.data};
            ST_BUF_RD:   acc_q <= '{1'b0, req_q.addr, 16'h0000};
            ST_BUF_DAT:  acc_q <= '{1'b1, req_q.addr, req_q.data};
            ST_BUF_CONF: acc_q <= '{1'b1, req_q.addr, {8'h00, fsr_pkg::CMD_CONFIRM}};
            ST_STAT_RD:  acc_q <= '{1'b0, req_q.addr, 16'h0000};
            ST_ID_BLK:   acc_q <= '{1'b0, blk_base + fsr_pkg::ID_BLOCK_OFS, 16'h0000};
            ST_ID_MST:   acc_q <= '{1'b0, fsr_pkg::ID_MASTER_OFS, 16'h0000};
            default:     acc_q <= '{1'b1, req_q.addr, {8'h00, fsr_pkg::CMD_READ_ARRAY}};
          endcase
          unique case (state_q)
            ST_CMD2, ST_BUF_CONF: ret_q <= ST_WAIT_LOW;
            ST_BUF_RD:            ret_q <= ST_BUF_EVAL;
            ST_BUF_DAT:           ret_q <= ST_BUF_CONF;
            ST_STAT_RD:           ret_q <= ST_STAT_CHK;
            ST_ID_BLK:            ret_q <= ST_ID_MST;
            ST_ID_MST:            ret_q <= ST_ID_END;
            ST_ID_END:            ret_q <= ST_ARRAY;
            default:              ret_q <= ST_FINISH;
          endcase
          state_q <= (state_q == ST_ID_END) ? ST_ARRAY : ST_ACC;
          tim_q   <= fsr_pkg::TIM_W'(fsr_pkg::ACC_CYC - 1);
        end
        ST_FINISH: state_q <= ST_IDLE;
        ST_RST_LOW: begin
          if (tim_q == '0) begin
            state_q <= ST_RST_REC;
            tim_q   <= fsr_pkg::TIM_W'(fsr_pkg::RST_REC_CYC - 1);
          end else begin
            tim_q <= tim_q - 1'b1;
          end
        end
        ST_RST_REC: begin
          if (tim_q == '0) begin
            state_q <= ST_IDLE;
          end else begin
            tim_q <= tim_q - 1'b1;
          end
        end
      endcase
    end
  end

  // read capture; ID_END skips its own command write and goes straight to ARRAY
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      rdata_q <= '0;
    end else if (state_q == ST_GAP && !acc_q.wr) begin
      rdata_q <= i_flash_dq;
    end
  end

  // results; status bytes masked as they are captured, lock codes taken whole
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_result <= '0;
    end else if (rst_req) begin
      o_result <= '0;
    end else if (state_q == ST_IDLE && i_start) begin
      o_result <= '0;
    end else begin
      if (state_q == ST_BUF_EVAL) begin
        o_result.ext_status <= rdata_q[7:0] & fsr_pkg::EXT_MASK;
      end
      if (state_q == ST_STAT_CHK) begin
        o_result.main_status <= rdata_q[7:0] & fsr_pkg::MAIN_MASK;
        o_result.protect     <= rdata_q[fsr_pkg::MAIN_PROTECT_BIT];
      end
      if (state_q == ST_ID_MST) begin
        o_result.block_lock <= rdata_q[7:0];
      end
      if (state_q == ST_ID_END) begin
        o_result.master_lock <= rdata_q[7:0];
      end
    end
  end

  // status flags to the user
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_busy           <= 1'b0;
      o_done           <= 1'b0;
      o_reissue_needed <= 1'b0;
    end else begin
      o_busy <= (state_q != ST_IDLE) || i_start;
      o_done <= (state_q == ST_FINISH) && !rst_req;
      if (rst_req && state_q != ST_IDLE && !in_reset) begin
        o_reissue_needed <= 1'b1;
      end else if (state_q == ST_IDLE && i_start && !rst_req) begin
        o_reissue_needed <= 1'b0;
      end
    end
  end

  // pins; data is driven one cycle past the write strobe for hold time
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_flash_addr        <= '0;
      o_flash_dq          <= '0;
      o_flash_dq_oe       <= 1'b0;
      o_chip_select_a_n   <= 1'b1;
      o_oe_n              <= 1'b1;
      o_we_n              <= 1'b1;
      o_reset_powerdown_n <= 1'b0;
    end else begin
      o_flash_addr        <= acc_q.addr;
      o_flash_dq          <= acc_q.data;
      o_flash_dq_oe       <= acc_q.wr && (state_q == ST_ACC || state_q == ST_GAP);
      o_chip_select_a_n   <= !(state_q == ST_ACC || state_q == ST_GAP);
      o_oe_n              <= !(state_q == ST_ACC && !acc_q.wr);
      o_we_n              <= !(state_q == ST_ACC && acc_q.wr);
      o_reset_powerdown_n <= !rst_req && state_q != ST_RST_LOW;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  sequence prot_seen_s;
    state_q == ST_STAT_CHK && rdata_q[fsr_pkg::MAIN_PROTECT_BIT] && !rst_req;
  endsequence
  sequence id_cmd_s;
    state_q == ST_ACC && acc_q.wr && acc_q.data[7:0] == fsr_pkg::CMD_READ_ID
      && ret_q == ST_ID_BLK;
  endsequence

  main_mask_a: assert property (o_result.main_status[2] == 1'b0 &&
                              o_result.main_status[0] == 1'b0)
    else $error("reserved main status bits not masked");
  ext_mask_a: assert property (o_result.ext_status[6:0] == 7'h00)
    else $error("reserved extended status bits not masked");
  protect_id_a: assert property (prot_seen_s |=> id_cmd_s)
    else $error("protect flag did not start identifier read");
  lock_codes_a: assert property (prot_seen_s |=> ##[1:40] state_q == ST_ID_MST)
    else $error("lock code read did not follow");
  reissue_flag_a: assert property ((rst_req && state_q != ST_IDLE && !in_reset)
                                   |=> o_reissue_needed && !o_reset_powerdown_n)
    else $error("aborted operation not flagged for reissue");
  select_oe_a: assert property (!o_oe_n |-> !o_chip_select_a_n && !o_flash_dq_oe)
    else $error("output enable without select or with host drive");
  supply_reset_a: assert property (!i_supply_ok |=> !o_reset_powerdown_n)
    else $error("reset pin not low while supply is bad");
  pin_toggle_a: assert property ($rose(i_sys_reset) |=> !o_reset_powerdown_n [*2])
    else $error("system reset did not toggle the reset pin");

endmodule

// File: testbench/fsr_flash_model.sv
// behavioural flash device seen from its pins, for the host bench
`timescale 1ns/1ps
module fsr_flash_model (
  // timekeeping only, the device has no clock
  input  wire logic        i_tick,
  // bench configuration
  input  wire logic        i_block_locked,
  input  wire logic        i_master_locked,
  input  wire logic        i_buf_free,
  input  wire logic [15:0] i_busy_cyc,
  input  wire logic        i_pulse_mode,
  // flash pins
  input  wire logic [22:0] i_addr,
  input  wire logic [15:0] i_dq,
  input  wire logic        i_cs_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  input  wire logic        i_rst_n,
  output logic [15:0]      o_dq,
  output logic             o_completion_pin
);
  typedef enum logic [1:0] {FSR_M_ARRAY, FSR_M_STATUS, FSR_M_ID, FSR_M_XSTAT} fsr_mode_t;
  fsr_mode_t   mode_q;
  logic [2:0]  stage_q;   // 1: second word due, 2..4: buffer count, data, confirm
  logic        protect_q;
  logic        go_q = 1'b0;
  logic        go_seen_q = 1'b0;
  logic [15:0] busy_q;
  logic [15:0] last_q;
  logic [7:0]  rd;
  logic [3:0]  pulse_q;
  logic        was_busy_q;
  // typical completion pulse width counted in bench ticks
  localparam int PULSE_TICKS = 250 / fsr_pkg::CLK_NS;

  always @(posedge i_we_n or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_q    <= FSR_M_ARRAY;
      stage_q   <= 3'h0;
      protect_q <= 1'b0;
    end else if (!i_cs_n) begin
      if (stage_q == 3'h1 || stage_q == 3'h4) begin
        go_q      <= ~go_q;
        stage_q   <= 3'h0;
        mode_q    <= FSR_M_STATUS;
        protect_q <= i_block_locked | i_master_locked;
      end else if (stage_q != 3'h0) begin
        stage_q <= stage_q + 3'h1;
      end else begin
        case (i_dq[7:0])
          8'hff: mode_q <= FSR_M_ARRAY;
          8'h70: mode_q <= FSR_M_STATUS;
          8'h90: mode_q <= FSR_M_ID;
          8'he8: begin
            mode_q  <= FSR_M_XSTAT;
            stage_q <= i_buf_free ? 3'h2 : 3'h0;
          end
          default: stage_q <= 3'h1;
        endcase
      end
    end
  end

  // reset drops the algorithm at once, well inside the allowed low time
  always @(posedge i_tick or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_q    <= 16'h0;
      go_seen_q <= go_q;
    end else if (go_q != go_seen_q) begin
      busy_q    <= i_busy_cyc;
      go_seen_q <= go_q;
    end else if (busy_q != 16'h0) begin
      busy_q <= busy_q - 16'h1;
    end
  end

  always @(posedge i_tick) begin
    last_q <= o_dq;
  end

  // pulse mode: pin stays released while busy and pulses low once the algorithm ends
  always @(posedge i_tick or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pulse_q    <= 4'h0;
      was_busy_q <= 1'b0;
    end else begin
      was_busy_q <= busy_q != 16'h0;
      if (was_busy_q && busy_q == 16'h0 && i_pulse_mode) begin
        pulse_q <= 4'(PULSE_TICKS);
      end else if (pulse_q != 4'h0) begin
        pulse_q <= pulse_q - 4'h1;
      end
    end
  end

  // level mode: pin pulled low while the algorithm runs, whatever select and enable do
  assign o_completion_pin = !i_rst_n ? 1'b1 :
                            i_pulse_mode ? pulse_q == 4'h0 :
                            busy_q == 16'h0;

  // reserved bits carry junk so that a host that forgets to mask is caught
  always_comb begin
    case (mode_q)
      FSR_M_STATUS: rd = {busy_q == 16'h0, 4'h0, 1'b1, protect_q, 1'b1};
      FSR_M_XSTAT:  rd = {i_buf_free, busy_q != 16'h0 ? ~last_q[6:0] : 7'h55};
      FSR_M_ID:     rd = i_addr[1:0] == 2'h2 ? {7'h0, i_block_locked} :
                         i_addr[1:0] == 2'h3 ? {7'h0, i_master_locked} : 8'h00;
      default:      rd = 8'h3c;
    endcase
  end

  // undriven bus shows a changing pattern, never the last value
  assign o_dq = (!i_cs_n && !i_oe_n && i_rst_n) ? {8'h00, rd} : ~last_q;
endmodule

// File: testbench/fsr_host_test.sv
// self-checking bench for the flash status-reporting host controller
`timescale 1ns/1ps
module fsr_host_test;
  logic                 clk;
  logic                 rst;
  logic                 supply_ok;
  logic                 sys_reset;
  logic                 start;
  fsr_pkg::fsr_req_t    req;
  logic                 busy;
  logic                 done;
  logic                 reissue;
  fsr_pkg::fsr_result_t res;
  logic [22:0]          addr;
  logic [15:0]          host_dq;
  logic                 host_oe;
  logic [15:0]          dev_dq;
  logic                 cs_n;
  logic                 oe_n;
  logic                 we_n;
  logic                 rst_pin_n;
  logic                 cmpl_pin;
  logic                 pulse_mode;
  logic                 blk_lk;
  logic                 mst_lk;
  logic                 buf_free;
  logic [15:0]          busy_cyc;
  int                   n_errors;
  int                   comparisons;
  int                   k;
  wire  [15:0]          dq_bus = host_oe ? host_dq : dev_dq;

  fsr_host u_dut (
    .i_ref_clk(clk), .i_reset(rst), .i_supply_ok(supply_ok), .i_sys_reset(sys_reset),
    .i_start(start), .i_req(req), .o_busy(busy), .o_done(done), .o_reissue_needed(reissue),
    .o_result(res), .o_flash_addr(addr), .i_flash_dq(dq_bus), .o_flash_dq(host_dq),
    .o_flash_dq_oe(host_oe), .o_chip_select_a_n(cs_n), .o_oe_n(oe_n), .o_we_n(we_n),
    .o_reset_powerdown_n(rst_pin_n), .i_completion_pin(cmpl_pin)
  );

  fsr_flash_model u_flash (
    .i_tick(clk), .i_block_locked(blk_lk), .i_master_locked(mst_lk), .i_buf_free(buf_free),
    .i_busy_cyc(busy_cyc), .i_addr(addr), .i_dq(dq_bus), .i_cs_n(cs_n), .i_oe_n(oe_n),
    .i_we_n(we_n), .i_rst_n(rst_pin_n), .o_dq(dev_dq), .o_completion_pin(cmpl_pin),
    .i_pulse_mode(pulse_mode)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic kick(input fsr_pkg::fsr_op_t kind, input logic [7:0] cmd);
    @(negedge clk);
    start = 1'b1;
    req   = '{kind: kind, cmd: cmd, addr: 23'h020010, data: 16'ha5c3};
    @(negedge clk);
    start = 1'b0;
  endtask

  task automatic run(input fsr_pkg::fsr_op_t kind, input logic [7:0] cmd);
    kick(kind, cmd);
    k = 0;
    while (done !== 1'b1 && k < 3000) begin
      @(negedge clk);
      k++;
    end
    check(done, 1'b1);
  endtask

  task automatic end_sim;
    if (n_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // under two thousand cycles are expected; this is twenty times that
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    end_sim;
  end

  initial begin
    n_errors = 0; comparisons = 0;
    rst = 1'b1; supply_ok = 1'b1; sys_reset = 1'b0; start = 1'b0; req = '0;
    blk_lk = 1'b0; mst_lk = 1'b0; buf_free = 1'b1; busy_cyc = 16'd30;
    pulse_mode = 1'b0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    run(fsr_pkg::FSR_OP_TWO_CYCLE, 8'h40);
    check(res.main_status, 8'h80);
    check(res.protect, 1'b0);
    for (int i = 1; i < 4; i++) begin
      blk_lk = i[0];
      mst_lk = i[1];
      run(fsr_pkg::FSR_OP_TWO_CYCLE, 8'h20);
      check(res.main_status, 8'h82);
      check({res.block_lock, res.master_lock}, {7'h0, i[0], 7'h0, i[1]});
    end
    blk_lk = 1'b0; mst_lk = 1'b0;
    run(fsr_pkg::FSR_OP_BUFFER, 8'he8);
    check(res.ext_status, 8'h80);
    buf_free = 1'b0;
    run(fsr_pkg::FSR_OP_BUFFER, 8'he8);
    check(res.ext_status, 8'h00);
    // long algorithm cut by a system reset
    buf_free = 1'b1; busy_cyc = 16'd400;
    kick(fsr_pkg::FSR_OP_TWO_CYCLE, 8'h40);
    k = 0;
    while (cmpl_pin !== 1'b0 && k < 500) begin
      @(negedge clk);
      k++;
    end
    repeat (5) @(negedge clk);
    check({cmpl_pin, cs_n}, 2'b01);
    sys_reset = 1'b1;
    repeat (3) @(negedge clk);
    check({rst_pin_n, cmpl_pin, reissue}, 3'b011);
    check(res, 33'h0);
    sys_reset = 1'b0; busy_cyc = 16'd30;
    k = 0;
    while (busy !== 1'b0 && k < 200) begin
      @(negedge clk);
      k++;
    end
    check(busy, 1'b0);
    run(fsr_pkg::FSR_OP_TWO_CYCLE, 8'h40);
    check({reissue, res.main_status}, 9'h080);
    // pulse mode: the low pulse comes well after the host has finished
    pulse_mode = 1'b1; busy_cyc = 16'd200;
    run(fsr_pkg::FSR_OP_TWO_CYCLE, 8'h40);
    k = 0;
    repeat (250) begin
      @(negedge clk);
      if (cmpl_pin === 1'b0) k++;
    end
    check(k, 33'd10);
    pulse_mode = 1'b0; busy_cyc = 16'd30;
    supply_ok = 1'b0;
    repeat (3) @(negedge clk);
    check(rst_pin_n, 1'b0);
    supply_ok = 1'b1;
    repeat (60) @(negedge clk);
    check(rst_pin_n, 1'b1);
    end_sim;
  end
endmodule
